/* File: bench/mqws_wr.sv */
// writer-side model driving the write port pins
`timescale 1ns/100ps
`include "mqws_regs.svh"

module mqws_wr
   import mqws_pkg::*;
(
   input wire logic clk_sys,
   input wire logic prog_busy,
   output mqws_pins_s pins
);
   // ***************************
   // pin cycles
   // ***************************
   initial
   begin
      pins = '0;
      pins.write_en_n = 1'b1;
   end

   task automatic drive(input logic wen_n, input logic [`MQWS_ADDR_W-1:0] addr, input logic qs, input logic fs,
      input logic [`MQWS_DATA_W-1:0] dv);
      @(posedge clk_sys);
      pins.write_en_n <= wen_n;
      pins.write_queue_address <= addr;
      pins.queue_select_strobe <= qs & ~prog_busy;
      pins.flag_select_strobe <= fs & ~qs;
      pins.data <= dv;
   endtask

   // idle cycles scramble address and data so stale values never look valid
   task automatic idle();
      drive(1'b1, ~pins.write_queue_address, 1'b0, 1'b0, ~pins.data);
   endtask

   task automatic mode(input logic m);
      @(posedge clk_sys);
      pins.flag_mode_polled <= m;
   endtask
endmodule // mqws_wr

/* File: bench/tb.sv */
// self-checking bench for the write port and flag-device select block
`timescale 1ns/100ps
`include "mqws_regs.svh"

module tb
   import mqws_pkg::*;
;
   localparam logic [2:0] ID = 3'h2;
   logic clk_sys, rst, word_ready, prog_busy;
   logic [3:0] qaf_n;
   mqws_pins_s pins;
   logic write_ready_q, write_dropped_q, word_valid_q, oe_q, sync_q;
   mqws_word_s word_q;
   mqws_word_s w;
   mqws_word_s got[$];
   logic [1:0] active_queue_q, cur;
   logic [3:0] bus_q;
   logic [35:0] d;
   int mismatches, check_count, drops, syncs, oes;

   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   mqws_top i_mqws_top (.clk_sys(clk_sys), .rst(rst), .ce(1'b1), .write_en_n(pins.write_en_n),
      .write_queue_address(pins.write_queue_address), .queue_select_strobe(pins.queue_select_strobe),
      .flag_select_strobe(pins.flag_select_strobe), .flag_mode_polled(pins.flag_mode_polled),
      .write_data(pins.data), .device_id_strap(ID), .queue_almost_full_n(qaf_n),
      .write_ready_q(write_ready_q), .write_dropped_q(write_dropped_q), .word_valid_q(word_valid_q),
      .word_ready(word_ready), .word_q(word_q), .active_queue_q(active_queue_q),
      .almost_full_flag_bus_q(bus_q), .almost_full_flag_bus_oe_q(oe_q), .flag_bus_sync_q(sync_q));
   mqws_wr i_mqws_wr (.clk_sys(clk_sys), .prog_busy(prog_busy), .pins(pins));

   always @(posedge clk_sys)
   begin
      if (word_valid_q === 1'b1 && word_ready === 1'b1) got.push_back(word_q);
      if (write_dropped_q === 1'b1) drops++;
      if (sync_q === 1'b1) syncs++;
      if (oe_q === 1'b1) oes++;
   end

   // ***************************
   // helpers
   // ***************************
   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] act);
      check_count++;
      if (exp !== act)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, act);
      end
   endtask

   task automatic pause(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic take(input logic [1:0] q, input logic [35:0] dv);
      for (int i = 0; i < 20 && got.size() == 0; i++) pause(1);
      w = (got.size() != 0) ? got.pop_front() : '1;
      chk("word queue", q, w.queue);
      chk("word data", dv, w.data);
   endtask

   // writes on the select cycle and the three after it: two land in the old queue
   task automatic sel_burst(input logic [1:0] nq);
      for (int k = 0; k < 4; k++) i_mqws_wr.drive(1'b0, {ID, k == 0 ? nq : ~nq}, k == 0, 1'b0, d + k);
      i_mqws_wr.idle();
      for (int k = 0; k < 4; k++) take(k < 2 ? cur : nq, d + k);
      cur = nq;
      d = d + 4;
   endtask

   task automatic results();
      if (mismatches == 0 && check_count > 0)
      begin
         $display("Result: passed");
      end
      else
      begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // ***************************
   // tests
   // ***************************
   initial
   begin
      pause(5000);
      mismatches++;
      results();
   end

   initial
   begin
      rst = 1'b1;
      word_ready = 1'b1;
      prog_busy = 1'b1;
      qaf_n = 4'hA;
      d = 36'h100;
      cur = 2'h3;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      pause(2);
      chk("ready", 1, write_ready_q);
      chk("valid", 0, word_valid_q);
      chk("queue", 0, active_queue_q);
      chk("bus", 4'hF, bus_q);
      chk("oe", 0, oe_q);
      chk("sync", 0, sync_q);
      pause(4);
      prog_busy = 1'b0;
      i_mqws_wr.drive(1'b1, {ID, 2'h3}, 1'b1, 1'b0, d);
      i_mqws_wr.idle();
      pause(6);
      chk("queue select", 3, active_queue_q);
      for (int q = 0; q < 4; q++) sel_burst(q[1:0]);
      i_mqws_wr.drive(1'b1, {ID ^ 3'h5, 2'h1}, 1'b1, 1'b0, d);
      i_mqws_wr.idle();
      pause(6);
      chk("foreign select", cur, active_queue_q);
      i_mqws_wr.drive(1'b1, {ID ^ 3'h1, 2'h0}, 1'b0, 1'b1, d);
      i_mqws_wr.idle();
      pause(6);
      chk("foreign flag oe", 0, oe_q);
      i_mqws_wr.drive(1'b0, {ID, 2'h1}, 1'b0, 1'b1, d);
      i_mqws_wr.idle();
      pause(6);
      chk("flag oe", 1, oe_q);
      chk("flag bus", 4'hA, bus_q);
      chk("flag keeps queue", cur, active_queue_q);
      take(cur, d);
      @(posedge clk_sys) qaf_n <= 4'h5;
      pause(3);
      chk("flag bus follow", 4'h5, bus_q);
      i_mqws_wr.mode(1'b1);
      pause(12);
      syncs = 0;
      oes = 0;
      pause(16);
      chk("sync pulses", 2, syncs);
      chk("polled oe slots", 2, oes);
      i_mqws_wr.mode(1'b0);
      @(posedge clk_sys) word_ready <= 1'b0;
      pause(2);
      drops = 0;
      d = d + 1;
      for (int k = 0; k < 3; k++) i_mqws_wr.drive(1'b0, {ID, 2'h0}, 1'b0, 1'b0, d + k);
      i_mqws_wr.idle();
      pause(6);
      chk("full ready", 0, write_ready_q);
      chk("drops", 1, drops);
      @(posedge clk_sys) word_ready <= 1'b1;
      take(cur, d);
      take(cur, d + 1);
      pause(4);
      chk("drained", 0, word_valid_q);
      chk("extra words", 0, got.size());
      results();
   end
endmodule // tb

/* File: core/mqws_buf2.sv */
// two-entry valid/ready buffer between the write port and the queue memory
`timescale 1ns/100ps
`include "mqws_regs.svh"

module mqws_buf2
#(
   parameter int WIDTH = 38
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic in_valid,
   output logic in_ready_q,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid_q,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data_q
);

   logic [WIDTH-1:0] tail_q;
   logic tail_v_q;
   logic push;
   logic pop;
   logic tail_v_d;

   assign push = in_valid && in_ready_q;
   assign pop = out_valid_q && out_ready;

   always_comb
   begin
      tail_v_d = tail_v_q;
      if (pop && tail_v_q)
         tail_v_d = 1'b0;
      else if (push && out_valid_q && !pop)
         tail_v_d = 1'b1;
   end

   // ******************************
   // head and tail storage
   // ******************************
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         out_valid_q <= 1'b0;
         tail_v_q <= 1'b0;
         in_ready_q <= 1'b1;
         out_data_q <= '0;
         tail_q <= '0;
      end
      else if (ce)
      begin
         tail_v_q <= tail_v_d;
         // ready flop follows the tail so a stall is seen one cycle later, never lost
         in_ready_q <= !tail_v_d;
         if (pop)
         begin
            if (tail_v_q)
               out_data_q <= tail_q;
            else if (push)
               out_data_q <= in_data;
            out_valid_q <= tail_v_q || push;
         end
         else if (push && !out_valid_q)
         begin
            out_data_q <= in_data;
            out_valid_q <= 1'b1;
         end
         if (push && (tail_v_q ? pop : (out_valid_q && !pop)))
            tail_q <= in_data;
      end
   end

endmodule // mqws_buf2

/* File: core/mqws_top.sv */
// write-side queue and flag-device selection for a four-queue expandable buffer
`timescale 1ns/100ps
`include "mqws_regs.svh"

module mqws_top
   import mqws_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic ce,
   input wire logic write_en_n,
   input wire logic [`MQWS_ADDR_W-1:0] write_queue_address,
   input wire logic queue_select_strobe,
   input wire logic flag_select_strobe,
   input wire logic flag_mode_polled,
   input wire logic [`MQWS_DATA_W-1:0] write_data,
   input wire logic [`MQWS_DEV_W-1:0] device_id_strap,
   input wire logic [`MQWS_FLAG_W-1:0] queue_almost_full_n,
   output logic write_ready_q,
   output logic write_dropped_q,
   output logic word_valid_q,
   input wire logic word_ready,
   output mqws_word_s word_q,
   output logic [`MQWS_QUEUE_W-1:0] active_queue_q,
   output logic [`MQWS_FLAG_W-1:0] almost_full_flag_bus_q,
   output logic almost_full_flag_bus_oe_q,
   output logic flag_bus_sync_q
);

   // ******************************
   // pin synchronisers
   // ******************************
   mqws_pins_s pins_raw;
   mqws_pins_s pin_s1_q;
   mqws_pins_s pin_s2_q;
   mqws_pins_s pins_idle;
   logic [`MQWS_DEV_W-1:0] id_s1_q;
   logic [`MQWS_DEV_W-1:0] id_s2_q;

   assign pins_raw = '{write_en_n: write_en_n, write_queue_address: write_queue_address,
                       queue_select_strobe: queue_select_strobe, flag_select_strobe: flag_select_strobe,
                       flag_mode_polled: flag_mode_polled, data: write_data};

   always_comb
   begin
      pins_idle = '0;
      pins_idle.write_en_n = 1'b1;
   end

   // every write-port pin and the id strap see the same two-stage delay, so their relative timing is kept
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pin_s1_q <= pins_idle;
         pin_s2_q <= pins_idle;
         id_s1_q <= `MQWS_RST_DEV;
         id_s2_q <= `MQWS_RST_DEV;
      end
      else if (ce)
      begin
         pin_s1_q <= pins_raw;
         pin_s2_q <= pin_s1_q;
         id_s1_q <= device_id_strap;
         id_s2_q <= id_s1_q;
      end
   end

   // ******************************
   // device identity strap
   // ******************************
   logic [1:0] id_hold_q;
   mqws_dev_t dev_id_q;

   // strap is caught only in the first cycles after reset; later changes are ignored
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         id_hold_q <= 2'h0;
         dev_id_q <= `MQWS_RST_DEV;
      end
      else if (ce && id_hold_q != `MQWS_ID_HOLD)
      begin
         id_hold_q <= id_hold_q + 2'h1;
         dev_id_q <= id_s2_q;
      end
   end

   // ******************************
   // address decode
   // ******************************
   mqws_queue_t addr_queue;
   mqws_dev_t addr_dev;
   logic addr_hit;
   logic qsel_hit;
   logic fsel_hit;

   assign addr_queue = pin_s2_q.write_queue_address[`MQWS_QUEUE_LSB +: `MQWS_QUEUE_W];
   assign addr_dev = pin_s2_q.write_queue_address[`MQWS_DEV_LSB +: `MQWS_DEV_W];
   assign addr_hit = addr_dev == dev_id_q;
   assign qsel_hit = pin_s2_q.queue_select_strobe && addr_hit;
   assign fsel_hit = pin_s2_q.flag_select_strobe && addr_hit;

   // ******************************
   // queue selection pipeline
   // ******************************
   logic pend_valid_q;
   mqws_queue_t pend_queue_q;

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pend_valid_q <= 1'b0;
         pend_queue_q <= `MQWS_RST_QUEUE;
      end
      else if (ce)
      begin
         pend_valid_q <= qsel_hit;
         if (qsel_hit)
            pend_queue_q <= addr_queue;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         active_queue_q <= `MQWS_RST_QUEUE;
      else if (ce && pend_valid_q)
         active_queue_q <= pend_queue_q;
   end

   // ******************************
   // write path
   // ******************************
   logic wr_req;
   logic buf_in_ready;
   mqws_word_s wr_word;

   // flag strobe does not block it
   assign wr_req = !pin_s2_q.write_en_n;
   assign wr_word = '{queue: active_queue_q, data: pin_s2_q.data};

   mqws_buf2 #(.WIDTH($bits(mqws_word_s))) u_buf
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .in_valid(wr_req),
      .in_ready_q(buf_in_ready),
      .in_data(wr_word),
      .out_valid_q(word_valid_q),
      .out_ready(word_ready),
      .out_data_q(word_q)
   );

   assign write_ready_q = buf_in_ready;

   // a write while the buffer is full cannot be held back at the pins, so it is reported
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         write_dropped_q <= 1'b0;
      else if (ce)
         write_dropped_q <= wr_req && !buf_in_ready;
   end

   // ******************************
   // flag bus ownership
   // ******************************
   logic own_q;
   mqws_dev_t slot_q;
   logic drive;
   mqws_flag_mode_e flag_mode;

   assign flag_mode = mqws_flag_mode_e'(pin_s2_q.flag_mode_polled);

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         own_q <= 1'b0;
      else if (ce && fsel_hit)
         own_q <= 1'b1;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         slot_q <= `MQWS_POLL_FIRST;
      else if (ce)
      begin
         if (flag_mode == MQWS_FLAG_POLLED)
            slot_q <= slot_q + 3'h1;
         else
            slot_q <= `MQWS_POLL_FIRST;
      end
   end

   always_comb
   begin
      case (flag_mode)
         MQWS_FLAG_POLLED: drive = slot_q == dev_id_q;
         MQWS_FLAG_DIRECT: drive = own_q;
         default: drive = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         almost_full_flag_bus_q <= `MQWS_FLAG_IDLE;
         almost_full_flag_bus_oe_q <= 1'b0;
         flag_bus_sync_q <= 1'b0;
      end
      else if (ce)
      begin
         almost_full_flag_bus_q <= drive ? queue_almost_full_n : `MQWS_FLAG_IDLE;
         almost_full_flag_bus_oe_q <= drive;
         flag_bus_sync_q <= flag_mode == MQWS_FLAG_POLLED && slot_q == `MQWS_POLL_FIRST;
      end
   end

   // ******************************
   // assertions
   // ******************************
   sequence s_select;
      qsel_hit && !pend_valid_q;
   endsequence

   sequence s_settle;
      ce [*2];
   endsequence

   property p_new_queue;
      @(posedge clk_sys) disable iff (rst)
      (s_select and ce) ##0 s_settle |=> active_queue_q == $past(addr_queue, 2);
   endproperty
   a_new_queue: assert property (p_new_queue) else $error("new queue not active after two edges");

   property p_old_queue;
      @(posedge clk_sys) disable iff (rst || !ce)
      s_select |=> active_queue_q == $past(active_queue_q);
   endproperty
   a_old_queue: assert property (p_old_queue) else $error("queue changed one edge after select");

   property p_sel_no_enable;
      @(posedge clk_sys) disable iff (rst || !ce)
      (qsel_hit && pin_s2_q.write_en_n) |=> pend_valid_q && pend_queue_q == $past(addr_queue);
   endproperty
   a_sel_no_enable: assert property (p_sel_no_enable) else $error("select lost with enable high");

   property p_mismatch;
      @(posedge clk_sys) disable iff (rst || !ce)
      (pin_s2_q.queue_select_strobe && !addr_hit) |=> !pend_valid_q;
   endproperty
   a_mismatch: assert property (p_mismatch) else $error("foreign id changed selection");

   property p_write;
      @(posedge clk_sys) disable iff (rst || !ce)
      (wr_req && buf_in_ready) |=> word_valid_q;
   endproperty
   a_write: assert property (p_write) else $error("enabled write not stored");

   property p_flag_own;
      @(posedge clk_sys) disable iff (rst || !ce)
      fsel_hit |=> own_q;
   endproperty
   a_flag_own: assert property (p_flag_own) else $error("flag select not latched");

   property p_direct_drive;
      @(posedge clk_sys) disable iff (rst || !ce)
      (flag_mode == MQWS_FLAG_DIRECT && own_q) |=> almost_full_flag_bus_oe_q;
   endproperty
   a_direct_drive: assert property (p_direct_drive) else $error("owner not driving flag bus");

   property p_poll_step;
      @(posedge clk_sys) disable iff (rst || !ce)
      (flag_mode == MQWS_FLAG_POLLED) |=> slot_q == $past(slot_q) + 3'h1;
   endproperty
   a_poll_step: assert property (p_poll_step) else $error("polled slot did not step");

   property p_poll_sync;
      @(posedge clk_sys) disable iff (rst || !ce)
      (flag_mode == MQWS_FLAG_POLLED && slot_q == `MQWS_POLL_FIRST) |=> flag_bus_sync_q;
   endproperty
   a_poll_sync: assert property (p_poll_sync) else $error("sync missing at slot zero");

endmodule // mqws_top

/* File: inc/mqws_pkg.sv */
// types shared by the multi-queue write port select block
`include "mqws_regs.svh"

package mqws_pkg;

   typedef logic [`MQWS_QUEUE_W-1:0] mqws_queue_t;
   typedef logic [`MQWS_DEV_W-1:0] mqws_dev_t;

   // pin group sampled on the write clock
   typedef struct packed {
      logic write_en_n;
      logic [`MQWS_ADDR_W-1:0] write_queue_address;
      logic queue_select_strobe;
      logic flag_select_strobe;
      logic flag_mode_polled;
      logic [`MQWS_DATA_W-1:0] data;
   } mqws_pins_s;

   // word handed to the queue memory
   typedef struct packed {
      mqws_queue_t queue;
      logic [`MQWS_DATA_W-1:0] data;
   } mqws_word_s;

   typedef enum logic [0:0] {
      MQWS_FLAG_DIRECT = 1'b0,
      MQWS_FLAG_POLLED = 1'b1
   } mqws_flag_mode_e;

endpackage

/* File: inc/mqws_regs.svh */
// constants for the multi-queue write port and flag-device selection block

`ifndef MQWS_REGS_SVH
`define MQWS_REGS_SVH

`define MQWS_ADDR_W 5
`define MQWS_QUEUE_W 2
`define MQWS_DEV_W 3
`define MQWS_QUEUE_LSB 0
`define MQWS_DEV_LSB 2
`define MQWS_DATA_W 36
`define MQWS_FLAG_W 4
`define MQWS_RST_QUEUE 2'h0
`define MQWS_RST_DEV 3'h0
`define MQWS_FLAG_IDLE 4'hF
`define MQWS_POLL_FIRST 3'h0
`define MQWS_ID_HOLD 2'h3

`endif
